// *** lpm_ctrl.sv ***
/*
  lpm_ctrl: low power mode controller with the power control register.
  assumes the core raises wake_irq only for interrupts enabled before idle,
  and unlock_in while the timed access window is open.
*/
`timescale 1ns/100ps
module lpm_ctrl #(
  parameter int unsigned START_CLOCKS = lpm_pkg::STOP_START_CLOCKS
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic unlock_in,
  input wire logic wake_irq_in,
  input wire logic ext_rst_in,
  input wire logic wdt_rst_in,
  input wire logic expanded_mode_in,
  input wire lpm_pkg::lpm_volt_t volt_in,
  output logic pf_irq_out,
  output logic por_flag_out,
  output lpm_pkg::lpm_pins_t pins_out,
  output lpm_pkg::lpm_state_t state_out
);
  localparam int unsigned CW = $clog2(START_CLOCKS + 1);
  localparam logic [CW-1:0] START_LAST = CW'(START_CLOCKS - 1);
  localparam logic [CW-1:0] IDLE_RST_LAST = CW'(lpm_pkg::IDLE_RESET_PERIODS - 1);
  localparam logic [CW-1:0] SHUT_LAST = CW'(lpm_pkg::SHUT_STEP_CYCLES - 1);

  lpm_pkg::lpm_volt_t volt_s;
  lpm_pkg::lpm_state_t state_reg;
  logic [CW-1:0] cnt_reg;
  logic idle_reg;
  logic stop_reg;
  logic epf_reg;
  logic por_reg;
  logic warn_flag_reg;
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic wdt_sync1_reg;
  logic wdt_sync2_reg;
  logic ext_rst;
  logic wdt_rst;
  logic reg_wr;
  logic reg_rd;
  logic any_rst;
  logic from_por_reg;

  lpm_sync #(.WIDTH(3)) u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(volt_in),
    .sync_out(volt_s)
  );

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
      wdt_sync1_reg <= 1'b0;
      wdt_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= ext_rst_in;
      rst_sync2_reg <= rst_sync1_reg;
      wdt_sync1_reg <= wdt_rst_in;
      wdt_sync2_reg <= wdt_sync1_reg;
    end
  end

  // watchdog has no clock in stop, so its reset counts in every state except stop
  assign ext_rst = rst_sync2_reg;
  assign wdt_rst = wdt_sync2_reg && (state_reg != lpm_pkg::LPM_STOP);
  assign reg_wr = wr_in && (addr_in == lpm_pkg::ADDR_PWR_CTRL);
  assign reg_rd = rd_in && (addr_in == lpm_pkg::ADDR_PWR_CTRL);
  assign any_rst = ext_rst || wdt_rst;

  // mode sequencer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= lpm_pkg::LPM_START;
      cnt_reg <= '0;
      from_por_reg <= 1'b1;
    end else if (volt_s.min_below && state_reg != lpm_pkg::LPM_SHUT_RST
                 && state_reg != lpm_pkg::LPM_SHUT_OSC
                 && state_reg != lpm_pkg::LPM_RETAIN) begin
      state_reg <= lpm_pkg::LPM_SHUT_RST;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        lpm_pkg::LPM_RUN: begin
          if (any_rst) begin
            state_reg <= lpm_pkg::LPM_RESET;
            cnt_reg <= '0;
          end else if (reg_wr && unlock_in && wdata_in[lpm_pkg::BIT_STOP]) begin
            state_reg <= lpm_pkg::LPM_STOP;
          end else if (reg_wr && wdata_in[lpm_pkg::BIT_IDLE]) begin
            state_reg <= lpm_pkg::LPM_IDLE;
          end
        end
        lpm_pkg::LPM_IDLE: begin
          if (any_rst) begin
            state_reg <= lpm_pkg::LPM_RESET;
            cnt_reg <= '0;
          end else if (wake_irq_in) begin
            state_reg <= lpm_pkg::LPM_RUN;
          end
        end
        lpm_pkg::LPM_STOP: begin
          if (ext_rst) begin
            state_reg <= lpm_pkg::LPM_START;
            cnt_reg <= '0;
            from_por_reg <= 1'b0;
          end
        end
        lpm_pkg::LPM_RESET: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == IDLE_RST_LAST) begin
            state_reg <= lpm_pkg::LPM_RUN;
          end
        end
        lpm_pkg::LPM_START: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == START_LAST) begin
            state_reg <= lpm_pkg::LPM_RUN;
          end
        end
        lpm_pkg::LPM_SHUT_RST: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == SHUT_LAST) begin
            state_reg <= lpm_pkg::LPM_SHUT_OSC;
            cnt_reg <= '0;
          end
        end
        lpm_pkg::LPM_SHUT_OSC: begin
          state_reg <= lpm_pkg::LPM_RETAIN;
        end
        lpm_pkg::LPM_RETAIN: begin
          if (!volt_s.min_below) begin
            state_reg <= lpm_pkg::LPM_START;
            cnt_reg <= '0;
            from_por_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // control bits; any reset path restores the reset values
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
      epf_reg <= 1'b0;
    end else if (any_rst || state_reg == lpm_pkg::LPM_START
                 || state_reg == lpm_pkg::LPM_SHUT_RST) begin
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
      epf_reg <= 1'b0;
    end else begin
      if (state_reg == lpm_pkg::LPM_IDLE && wake_irq_in) begin
        idle_reg <= 1'b0;
      end else if (reg_wr && state_reg == lpm_pkg::LPM_RUN) begin
        idle_reg <= wdata_in[lpm_pkg::BIT_IDLE];
      end
      if (reg_wr && unlock_in && state_reg == lpm_pkg::LPM_RUN) begin
        stop_reg <= wdata_in[lpm_pkg::BIT_STOP];
      end
      if (reg_wr) begin
        epf_reg <= wdata_in[lpm_pkg::BIT_EPF];
      end
    end
  end

  // power-on indicator survives non power-on resets
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      por_reg <= 1'b0;
    end else if (state_reg == lpm_pkg::LPM_START && from_por_reg) begin
      por_reg <= 1'b0;
    end else if (reg_wr && unlock_in) begin
      por_reg <= wdata_in[lpm_pkg::BIT_POR];
    end
  end

  // set wins over the read clear, so a low supply re-sets at once
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      warn_flag_reg <= 1'b0;
    end else if (state_reg == lpm_pkg::LPM_START && from_por_reg) begin
      warn_flag_reg <= 1'b0;
    end else if (volt_s.warn_below) begin
      warn_flag_reg <= 1'b1;
    end else if (reg_rd) begin
      warn_flag_reg <= 1'b0;
    end
  end

  // unused bits and non-read cycles show the reset value
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= lpm_pkg::PWR_CTRL_RESET;
    end else begin
      rdata_out <= lpm_pkg::PWR_CTRL_RESET;
      if (reg_rd) begin
        rdata_out[lpm_pkg::BIT_POR] <= por_reg;
        rdata_out[lpm_pkg::BIT_WARN] <= warn_flag_reg;
        rdata_out[lpm_pkg::BIT_EPF] <= epf_reg;
        rdata_out[lpm_pkg::BIT_STOP] <= stop_reg;
        rdata_out[lpm_pkg::BIT_IDLE] <= idle_reg;
      end
    end
  end

  assign pf_irq_out = warn_flag_reg && epf_reg;
  assign por_flag_out = por_reg;
  assign state_out = state_reg;

  always_comb begin
    pins_out = '0;
    pins_out.cpu_clk_en = (state_reg == lpm_pkg::LPM_RUN);
    pins_out.io_clk_en = (state_reg == lpm_pkg::LPM_RUN) || (state_reg == lpm_pkg::LPM_IDLE)
                         || (state_reg == lpm_pkg::LPM_RESET);
    pins_out.wdt_clk_en = pins_out.io_clk_en;
    pins_out.osc_en = (state_reg != lpm_pkg::LPM_STOP) && (state_reg != lpm_pkg::LPM_SHUT_OSC)
                      && (state_reg != lpm_pkg::LPM_RETAIN);
    pins_out.cpu_rst = (state_reg == lpm_pkg::LPM_RESET) || (state_reg == lpm_pkg::LPM_START)
                       || (state_reg == lpm_pkg::LPM_SHUT_RST)
                       || (state_reg == lpm_pkg::LPM_SHUT_OSC)
                       || (state_reg == lpm_pkg::LPM_RETAIN);
    pins_out.mem_ce_n = (state_reg == lpm_pkg::LPM_SHUT_OSC)
                        || (state_reg == lpm_pkg::LPM_RETAIN);
    pins_out.ale = (state_reg == lpm_pkg::LPM_IDLE) || (state_reg == lpm_pkg::LPM_STOP);
    pins_out.program_store_strobe = (state_reg == lpm_pkg::LPM_IDLE)
                                    || (state_reg == lpm_pkg::LPM_RUN);
    pins_out.p0_hiz = expanded_mode_in && ((state_reg == lpm_pkg::LPM_IDLE)
                      || (state_reg == lpm_pkg::LPM_STOP));
    pins_out.p2_addr = expanded_mode_in && (state_reg == lpm_pkg::LPM_IDLE);
    pins_out.lithium_sel = volt_s.li_below && (state_reg == lpm_pkg::LPM_RETAIN);
  end

  // flag and enable both set one edge after a low supply must raise the request
  a_warn_irq: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $past(volt_s.warn_below) && $past(state_reg) != lpm_pkg::LPM_START && epf_reg
    |-> pf_irq_out) else $error("irq missing with flag and enable set");
  a_warn_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $past(warn_flag_reg) && !$past(reg_rd) && $past(state_reg) != lpm_pkg::LPM_START
    |-> warn_flag_reg) else $error("warning flag lost without read");
  a_warn_set: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    volt_s.warn_below && !(state_reg == lpm_pkg::LPM_START && from_por_reg)
    |=> warn_flag_reg) else $error("flag not set when low");
  a_idle_wake: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_IDLE && wake_irq_in && !any_rst && !volt_s.min_below
    |=> state_reg == lpm_pkg::LPM_RUN && !idle_reg) else $error("idle wake failed");
  a_idle_rst_len: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(state_reg == lpm_pkg::LPM_RESET) && !volt_s.min_below
    |-> (state_reg == lpm_pkg::LPM_RESET || volt_s.min_below) [*8])
    else $error("idle reset too short");
  a_stop_exit: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_STOP && !ext_rst && !volt_s.min_below
    |=> state_reg == lpm_pkg::LPM_STOP) else $error("stop left without reset");
  a_stop_osc: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_STOP |-> !pins_out.osc_en && !pins_out.wdt_clk_en
    && pins_out.ale && !pins_out.program_store_strobe) else $error("stop pins wrong");
  a_idle_clks: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_IDLE |-> !pins_out.cpu_clk_en && pins_out.io_clk_en
    && pins_out.program_store_strobe) else $error("idle clocks wrong");
  a_shut_order: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    pins_out.mem_ce_n |-> pins_out.cpu_rst && !pins_out.osc_en)
    else $error("chip enable before reset");
  // only in run: start and shutdown legally clear stop_reg on their own, and a power-on start clears por_reg
  a_stop_lock: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_RUN && reg_wr && !unlock_in && !any_rst
    |=> $stable(stop_reg) && $stable(por_reg)) else $error("locked bit changed");

  c_idle_wake: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_IDLE ##1 state_reg == lpm_pkg::LPM_RUN);
  c_stop_exit: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_STOP ##1 state_reg == lpm_pkg::LPM_START);
  c_pf_irq: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) $rose(pf_irq_out));
  c_retain: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == lpm_pkg::LPM_RETAIN);
endmodule

// *** lpm_pkg.sv ***
/*
  lpm_pkg: constants, states and carrier structs for the low power mode controller.
  assumes one core clock; the analog monitor and the core sit outside.
*/
package lpm_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h00;
  localparam int unsigned BIT_POR = 6;
  localparam int unsigned BIT_WARN = 5;
  localparam int unsigned BIT_EPF = 3;
  localparam int unsigned BIT_STOP = 1;
  localparam int unsigned BIT_IDLE = 0;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam int unsigned IDLE_RESET_PERIODS = 24;
  localparam int unsigned STOP_START_CLOCKS = 21504;
  localparam int unsigned SHUT_STEP_CYCLES = 4;
  typedef enum {
    LPM_RUN, LPM_IDLE, LPM_STOP, LPM_RESET, LPM_START, LPM_SHUT_RST, LPM_SHUT_OSC, LPM_RETAIN
  } lpm_state_t;
  typedef struct packed {
    logic warn_below;
    logic min_below;
    logic li_below;
  } lpm_volt_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic io_clk_en;
    logic wdt_clk_en;
    logic osc_en;
    logic cpu_rst;
    logic mem_ce_n;
    logic ale;
    logic program_store_strobe;
    logic p0_hiz;
    logic p2_addr;
    logic lithium_sel;
  } lpm_pins_t;
endpackage

// *** lpm_sync.sv ***
/*
  lpm_sync: two flop synchroniser for a group of level inputs.
  assumes the inputs are quasi-static against the core clock.
*/
`timescale 1ns/100ps
module lpm_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// *** lpm_partner.sv ***
/*
  lpm_partner: supply monitor and timed access model facing the power mode controller.
  assumes the bench sets the supply level and unlock requests at clock edges.
*/
`timescale 1ns/100ps
module lpm_partner (
  input wire logic clk_sys_in,
  input wire logic [1:0] supply_in,
  input wire logic unlock_req_in,
  output lpm_pkg::lpm_volt_t volt_out,
  output logic unlock_out
);
  // supply 0 nominal, 1 below warning, 2 below minimum, 3 below lithium
  // thresholds nest, so a lower supply trips every higher one too
  assign volt_out = {supply_in >= 2'h1, supply_in >= 2'h2, supply_in == 2'h3};
  initial unlock_out = 1'b0;
  // window opens one cycle after the request, as after the unlock sequence
  always @(posedge clk_sys_in) begin
    unlock_out <= unlock_req_in;
  end
endmodule

// *** lpm_ctrl_tb_top.sv ***
/*
  lpm_ctrl_tb_top: self-checking bench for the power mode controller.
  assumes the partner model supplies the monitor levels and the unlock window.
*/
`timescale 1ns/100ps
module lpm_ctrl_tb_top;
  // short start delay keeps the run brief
  localparam int unsigned START_N = 20;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic wake_irq_in = 1'b0;
  logic ext_rst_in = 1'b0;
  logic wdt_rst_in = 1'b0;
  logic expanded_mode_in = 1'b1;
  logic [1:0] supply = 2'h0;
  logic unlock_req = 1'b0;
  logic unlock;
  lpm_pkg::lpm_volt_t volt;
  logic [7:0] rdata_out;
  logic pf_irq_out;
  logic por_flag_out;
  lpm_pkg::lpm_pins_t pins;
  lpm_pkg::lpm_state_t state;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  always #5 clk_sys_in = ~clk_sys_in;

  lpm_partner env_u (.clk_sys_in(clk_sys_in), .supply_in(supply), .unlock_req_in(unlock_req),
    .volt_out(volt), .unlock_out(unlock));
  lpm_ctrl #(.START_CLOCKS(START_N)) dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .unlock_in(unlock), .wake_irq_in(wake_irq_in),
    .ext_rst_in(ext_rst_in), .wdt_rst_in(wdt_rst_in), .expanded_mode_in(expanded_mode_in),
    .volt_in(volt), .pf_irq_out(pf_irq_out), .por_flag_out(por_flag_out),
    .pins_out(pins), .state_out(state));

  task automatic stop_test;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one idle cycle first so the unlock window is already open at the strobe
  task automatic wr(input logic [7:0] d, input logic unl);
    @(posedge clk_sys_in);
    unlock_req <= unl;
    @(posedge clk_sys_in);
    addr_in <= 8'h00;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    unlock_req <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(rdata_out, exp);
  endtask

  // call before the state is entered, so the first cycle is caught
  task automatic wait_st(input lpm_pkg::lpm_state_t s);
    n = 0;
    while (state != s && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(state, s);
  endtask

  task automatic dur(input lpm_pkg::lpm_state_t s, input int exp);
    n = 0;
    while (state == s && n < 30000) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(n, exp);
  endtask

  task automatic pulse(input logic sel);
    @(posedge clk_sys_in);
    if (sel) ext_rst_in <= 1'b1;
    else wdt_rst_in <= 1'b1;
    @(posedge clk_sys_in);
    ext_rst_in <= 1'b0;
    wdt_rst_in <= 1'b0;
  endtask

  task automatic set_supply(input logic [1:0] v);
    @(posedge clk_sys_in);
    supply <= v;
    repeat (4) @(posedge clk_sys_in);
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test;
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    wait_st(lpm_pkg::LPM_RUN);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    wr(8'h08, 1'b0);
    rd(8'h00, 8'h08);
    chk(pf_irq_out, 1'b0);
    set_supply(2'h1);
    chk(pf_irq_out, 1'b1);
    rd(8'h00, 8'h28);
    rd(8'h00, 8'h28);
    set_supply(2'h0);
    rd(8'h01, 8'h00);
    rd(8'h00, 8'h28);
    rd(8'h00, 8'h08);
    chk(pf_irq_out, 1'b0);
    wr(8'h4a, 1'b0);
    rd(8'h00, 8'h08);
    chk(state, lpm_pkg::LPM_RUN);
    wr(8'h48, 1'b1);
    rd(8'h00, 8'h48);
    chk(por_flag_out, 1'b1);
    wr(8'h49, 1'b0);
    wait_st(lpm_pkg::LPM_IDLE);
    // cpu, io, wdt, osc, ale, store strobe, p0 high-z, p2 address
    chk({pins.cpu_clk_en, pins.io_clk_en, pins.wdt_clk_en, pins.osc_en, pins.ale,
      pins.program_store_strobe, pins.p0_hiz, pins.p2_addr}, 8'h7f);
    @(posedge clk_sys_in);
    wake_irq_in <= 1'b1;
    @(posedge clk_sys_in);
    wake_irq_in <= 1'b0;
    wait_st(lpm_pkg::LPM_RUN);
    rd(8'h00, 8'h48);
    // watchdog reset first, then the reset pin
    // byte-wide memory on the first pass, expanded on the second
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_in);
      expanded_mode_in <= i[0];
      wr(8'h49, 1'b0);
      wait_st(lpm_pkg::LPM_IDLE);
      chk({pins.ale, pins.program_store_strobe, pins.p0_hiz, pins.p2_addr},
        {2'b11, i[0], i[0]});
      pulse(i[0]);
      wait_st(lpm_pkg::LPM_RESET);
      dur(lpm_pkg::LPM_RESET, 24);
      chk(state, lpm_pkg::LPM_RUN);
      rd(8'h00, 8'h40);
    end
    wr(8'h4a, 1'b1);
    wait_st(lpm_pkg::LPM_STOP);
    chk({pins.cpu_clk_en, pins.io_clk_en, pins.wdt_clk_en, pins.osc_en, pins.ale,
      pins.program_store_strobe, pins.p0_hiz, pins.p2_addr}, 8'h0a);
    pulse(1'b0);
    @(posedge clk_sys_in);
    wake_irq_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    wake_irq_in <= 1'b0;
    chk(state, lpm_pkg::LPM_STOP);
    pulse(1'b1);
    wait_st(lpm_pkg::LPM_START);
    dur(lpm_pkg::LPM_START, START_N);
    rd(8'h00, 8'h40);
    wr(8'h08, 1'b0);
    @(posedge clk_sys_in);
    supply <= 2'h2;
    wait_st(lpm_pkg::LPM_SHUT_RST);
    chk({pins.cpu_rst, pins.osc_en}, 2'h3);
    dur(lpm_pkg::LPM_SHUT_RST, lpm_pkg::SHUT_STEP_CYCLES);
    chk({pins.cpu_rst, pins.osc_en, pins.mem_ce_n}, 3'h5);
    wait_st(lpm_pkg::LPM_RETAIN);
    set_supply(2'h3);
    chk(pins.lithium_sel, 1'b1);
    @(posedge clk_sys_in);
    supply <= 2'h0;
    wait_st(lpm_pkg::LPM_START);
    wait_st(lpm_pkg::LPM_RUN);
    rd(8'h00, 8'h00);
    stop_test;
  end
endmodule
